// ### dts_pkg.sv
// constants, register map and types for the timed digital output sequencer
package dts_pkg;
  // wishbone register map (byte addresses)
  localparam int ADR_W = 9;
  localparam logic [8:0] ADDR_CTRL = 9'h000;
  localparam logic [8:0] ADDR_STAT = 9'h004;
  localparam logic [8:0] ADDR_REM = 9'h008;
  localparam int PAT_SEL_BIT = 8; // adr[8] set selects pattern store
  // control register fields
  localparam int CTRL_RUN = 0;
  localparam int CTRL_EXT = 1;
  localparam int CTRL_SEG = 2;
  localparam int CTRL_SEL_LO = 4;
  localparam logic [5:0] CTRL_RESET = 6'h00;
  // status register fields
  localparam int STAT_OUT = 0;
  localparam int STAT_RUN = 1;
  localparam int STAT_HOLD = 2;
  localparam int STAT_STEP_LO = 4;
  // pattern store shape
  localparam int NUM_PAT = 4;
  localparam int NUM_STEP = 16;
  localparam int IDX_W = 6;
  // duration word: hours, minutes, seconds, tenths
  localparam int DUR_W = 23;
  localparam int HRS_LO = 16;
  localparam int MIN_LO = 10;
  localparam int SEC_LO = 4;
  localparam int TEN_LO = 0;
  localparam int REM_W = 22;
  localparam logic [DUR_W-1:0] DUR_RESET = 23'h000000;
  // tick timing
  localparam int CLK_PERIOD_PS = 5000;
  localparam longint TICK_PERIOD_PS = 64'd100000000000;
  localparam int TICK_CYC = int'(TICK_PERIOD_PS / CLK_PERIOD_PS);
  typedef enum logic [1:0] {ST_IDLE, ST_LOAD, ST_TIME} dts_state_t;
endpackage

// ### dts_tick_if.sv
// tenth-second tick handshake between sequencer and divider
`timescale 1ns/10ps
interface dts_tick_if;
  logic en;
  logic clr;
  logic tick;
  modport seq (output en, output clr, input tick);
  modport div (input en, input clr, output tick);
endinterface

// ### dts_tick.sv
// tenth-second tick divider, frozen while the sequencer holds
`timescale 1ns/10ps
module dts_tick #(
  parameter int TICK_CYC = dts_pkg::TICK_CYC
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // sequencer side
  dts_tick_if.div tk
);
  logic [24:0] cnt;

  always_ff @(posedge clk_i) begin
    if (rst_i || tk.clr) begin
      cnt <= 25'h0000000;
    end else if (tk.en) begin
      if (cnt == 25'(TICK_CYC - 1)) begin
        cnt <= 25'h0000000;
      end else begin
        cnt <= cnt + 25'h0000001;
      end
    end
  end

  // tick gated by enable, so a hold can never swallow one
  // count frozen while disabled so resume keeps phase
  assign tk.tick = tk.en && (cnt == 25'(TICK_CYC - 1));

  chk_tick_single: assert property (@(posedge clk_i) disable iff (rst_i)
    tk.tick |=> !tk.tick) else $error("tick lasted more than one cycle");
endmodule

// ### dts_seq.sv
// timed digital output sequencer with wishbone registers
//
// Local design decisions: the Wishbone register port and the register addresses.
`timescale 1ns/10ps
module dts_seq #(
  parameter int TICK_CYC = dts_pkg::TICK_CYC
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [dts_pkg::ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // run sources
  input wire logic run_hold_i,
  input wire logic seg_active_i,
  // switched output
  output logic dout_o
);
  logic [5:0] ctrl;
  logic [dts_pkg::DUR_W-1:0] pat_mem [dts_pkg::NUM_PAT*dts_pkg::NUM_STEP];
  dts_pkg::dts_state_t state;
  logic [3:0] step;
  logic [dts_pkg::REM_W-1:0] rem;
  logic [dts_pkg::REM_W-1:0] dur;
  logic go;
  logic wr_req;
  logic [31:0] wmask;
  logic [dts_pkg::IDX_W-1:0] bus_idx;
  logic [dts_pkg::IDX_W-1:0] run_idx;
  dts_tick_if tk ();

  dts_tick #(.TICK_CYC(TICK_CYC)) u_tick (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .tk(tk)
  );

  // bus access decode; writes land on the ack edge
  assign wr_req = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;
  assign bus_idx = wb_adr_i[7:2];
  assign wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

  assign go = ctrl[dts_pkg::CTRL_RUN] && (!ctrl[dts_pkg::CTRL_EXT] || run_hold_i)
    && (!ctrl[dts_pkg::CTRL_SEG] || seg_active_i);

  assign run_idx = {ctrl[dts_pkg::CTRL_SEL_LO +: 2], step};

  always_comb begin
    logic [dts_pkg::DUR_W-1:0] w;
    int tot;
    w = pat_mem[run_idx];
    tot = int'(w[dts_pkg::HRS_LO +: 7]) * 36000 + int'(w[dts_pkg::MIN_LO +: 6]) * 600
      + int'(w[dts_pkg::SEC_LO +: 6]) * 10 + int'(w[dts_pkg::TEN_LO +: 4]);
    dur = tot[dts_pkg::REM_W-1:0];
  end

  // single-cycle ack, always answered even for unmapped addresses
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl <= dts_pkg::CTRL_RESET;
    end else if (wr_req && !wb_adr_i[dts_pkg::PAT_SEL_BIT] && wb_adr_i == dts_pkg::ADDR_CTRL) begin
      ctrl <= (ctrl & ~wmask[5:0]) | (wb_dat_i[5:0] & wmask[5:0]);
    end
  end

  // pattern store, byte-lane merged; no reset so it maps to ram
  always_ff @(posedge clk_i) begin
    if (wr_req && wb_adr_i[dts_pkg::PAT_SEL_BIT]) begin
      pat_mem[bus_idx] <= (pat_mem[bus_idx] & ~wmask[dts_pkg::DUR_W-1:0])
        | (wb_dat_i[dts_pkg::DUR_W-1:0] & wmask[dts_pkg::DUR_W-1:0]);
    end
  end

  // read data, registered with the ack
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h00000000;
    end else if (wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o) begin
      if (wb_adr_i[dts_pkg::PAT_SEL_BIT]) begin
        wb_dat_o <= 32'(pat_mem[bus_idx]);
      end else if (wb_adr_i == dts_pkg::ADDR_CTRL) begin
        wb_dat_o <= 32'(ctrl);
      end else if (wb_adr_i == dts_pkg::ADDR_STAT) begin
        wb_dat_o <= 32'({step, 1'b0, !go && state != dts_pkg::ST_IDLE,
          state != dts_pkg::ST_IDLE, dout_o});
      end else if (wb_adr_i == dts_pkg::ADDR_REM) begin
        wb_dat_o <= 32'(rem);
      end else begin
        wb_dat_o <= 32'h00000000;
      end
    end
  end

  // divider runs only while timing; cleared when the run bit drops
  assign tk.en = go && state == dts_pkg::ST_TIME;
  assign tk.clr = !ctrl[dts_pkg::CTRL_RUN];

  // step sequencer
  always_ff @(posedge clk_i) begin
    if (rst_i || !ctrl[dts_pkg::CTRL_RUN]) begin
      state <= dts_pkg::ST_IDLE;
      step <= 4'h0;
      rem <= 22'h000000;
      dout_o <= 1'b0;
    end else begin
      unique case (state)
        dts_pkg::ST_IDLE: begin
          state <= dts_pkg::ST_LOAD;
          step <= 4'h0;
        end
        dts_pkg::ST_LOAD: begin
          if (go) begin
            if (dur == 22'h000000) begin
              step <= step + 4'h1; // wraps past Off 8 too
            end else begin
              dout_o <= !step[0];
              rem <= dur;
              state <= dts_pkg::ST_TIME;
            end
          end
        end
        dts_pkg::ST_TIME: begin
          if (tk.tick) begin
            if (rem == 22'h000001) begin
              // Off 8 wraps to On 1
              step <= step + 4'h1;
              state <= dts_pkg::ST_LOAD;
            end else begin
              rem <= rem - 22'h000001;
            end
          end
        end
      endcase
    end
  end

  chk_out_phase: assert property (@(posedge clk_i) disable iff (rst_i)
    state == dts_pkg::ST_TIME |-> dout_o == !step[0]) else $error("output phase wrong");
  chk_dur_load: assert property (@(posedge clk_i) disable iff (rst_i)
    ctrl[dts_pkg::CTRL_RUN] && state == dts_pkg::ST_LOAD && go && dur != 22'h000000
    |=> state == dts_pkg::ST_TIME && rem == $past(dur)) else $error("duration not loaded");
  chk_step_next: assert property (@(posedge clk_i) disable iff (rst_i)
    ctrl[dts_pkg::CTRL_RUN] && state == dts_pkg::ST_TIME && tk.tick && rem == 22'h000001
    |=> state == dts_pkg::ST_LOAD && step == 4'($past(step) + 4'h1)) else $error("bad advance");
  chk_skip_keep: assert property (@(posedge clk_i) disable iff (rst_i)
    ctrl[dts_pkg::CTRL_RUN] && state == dts_pkg::ST_LOAD && go && dur == 22'h000000
    |=> dout_o == $past(dout_o) && state == dts_pkg::ST_LOAD) else $error("skip changed output");
  chk_wrap_start: assert property (@(posedge clk_i) disable iff (rst_i)
    ctrl[dts_pkg::CTRL_RUN] && state == dts_pkg::ST_TIME && tk.tick && rem == 22'h000001
    && step == 4'hF |=> step == 4'h0) else $error("no wrap after last off");
  // run bit starts at On 1
  chk_run_start: assert property (@(posedge clk_i) disable iff (rst_i)
    state == dts_pkg::ST_IDLE && ctrl[dts_pkg::CTRL_RUN] ##1 ctrl[dts_pkg::CTRL_RUN]
    |-> state == dts_pkg::ST_LOAD && step == 4'h0) else $error("run did not start");
  chk_seg_gate: assert property (@(posedge clk_i) disable iff (rst_i)
    ctrl[dts_pkg::CTRL_SEG] && !seg_active_i |-> !go && !tk.tick) else $error("ran outside seg");
  chk_hold_freeze: assert property (@(posedge clk_i) disable iff (rst_i)
    ctrl[dts_pkg::CTRL_RUN] && !go && state == dts_pkg::ST_TIME ##1 ctrl[dts_pkg::CTRL_RUN]
    |-> rem == $past(rem) && dout_o == $past(dout_o)) else $error("hold did not freeze");
  // bus ack is a single pulse
  chk_ack_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o |=> !wb_ack_o) else $error("ack held too long");

  cov_skip: cover property (@(posedge clk_i) disable iff (rst_i)
    state == dts_pkg::ST_LOAD && go && dur == 22'h000000);
  cov_wrap: cover property (@(posedge clk_i) disable iff (rst_i)
    state == dts_pkg::ST_TIME && tk.tick && rem == 22'h000001 && step == 4'hF);
  cov_hold: cover property (@(posedge clk_i) disable iff (rst_i)
    state == dts_pkg::ST_TIME && ctrl[dts_pkg::CTRL_RUN] && !go);
endmodule

// ### dts_load_model.sv
// load model switched by the sequenced output, with a run/hold source
`timescale 1ns/10ps
module dts_load_model (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // sequenced output and hold request
  input wire logic dout_i,
  input wire logic hold_req_i,
  // level change reports
  output logic evt_o,
  output logic lvl_o,
  output logic [31:0] len_o,
  // run/hold line back to the sequencer
  output logic run_hold_o
);
  logic last;
  logic [31:0] cnt;
  assign run_hold_o = !hold_req_i;
  // time each level of the load
  always @(posedge clk_i) begin
    evt_o <= 1'b0;
    if (rst_i) begin
      last <= 1'b0;
      cnt <= 32'h1;
    end else if (dout_i !== last) begin
      evt_o <= 1'b1;
      lvl_o <= last;
      len_o <= cnt;
      last <= dout_i;
      cnt <= 32'h1;
    end else begin
      cnt <= cnt + 32'h1;
    end
  end
endmodule

// ### test_dts_seq.sv
// self-checking bench for the timed output sequencer
`timescale 1ns/10ps
module test_dts_seq;
  localparam int TC = 4;
  typedef struct {logic lvl; int len;} dts_exp_t;
  logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic hold = 1'b0, seg = 1'b0, ack, dout, evt, lvl, rh;
  logic [8:0] adr = 9'h000;
  logic [3:0] sel = 4'hF;
  logic [31:0] wdat = 32'h0, rd, r1, wdo, len;
  logic [22:0] dur [64];
  logic [8:0] ra [3] = '{9'h000, 9'h004, 9'h00C};
  dts_exp_t q[$];
  dts_exp_t e;
  int fail_count = 0, n_checks = 0, cyc_n = 0;

  always #2.5 clk_i = ~clk_i;

  dts_seq #(.TICK_CYC(TC)) dts_seq_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(wdo), .wb_ack_o(ack), .run_hold_i(rh), .seg_active_i(seg), .dout_o(dout));
  dts_load_model dts_load_model_inst (.clk_i(clk_i), .rst_i(rst_i), .dout_i(dout),
    .hold_req_i(hold), .evt_o(evt), .lvl_o(lvl), .len_o(len), .run_hold_o(rh));

  task automatic chk(input logic [31:0] s, input logic [31:0] x);
    n_checks++;
    if (s !== x) begin
      fail_count++;
      $display("[FAIL] t=%0t seen=%0h exp=%0h", $time, s, x);
    end
  endtask

  // single classic cycle, held until ack is sampled
  task automatic wb(input logic w, input logic [8:0] a, input logic [31:0] d,
                    input logic [3:0] s);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= s;
    do @(posedge clk_i); while (ack !== 1'b1);
    rd = wdo;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask

  function automatic int tenths(input logic [22:0] w);
    return w[22:16] * 36000 + w[15:10] * 600 + w[9:4] * 10 + w[3:0];
  endfunction

  // two passes of a pattern, equal levels merged, zero steps cost one cycle
  task automatic predict(input int p);
    logic l;
    int acc;
    int d;
    bit first;
    l = 1'b0;
    acc = 0;
    first = 1'b1;
    for (int i = 0; i < 32; i++) begin
      d = tenths(dur[p * 16 + i % 16]);
      if (d == 0) begin
        acc++;
      end else begin
        if (l != !i[0]) begin
          q.push_back('{l, first ? 0 : acc});
          first = 1'b0;
          l = !i[0];
          acc = 0;
        end
        acc += d * TC + 1;
      end
    end
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // watcher: each output change while notes are queued is matched to the oldest note
  always @(posedge clk_i) begin
    if (evt === 1'b1 && q.size() > 0) begin
      e = q.pop_front();
      chk(lvl, e.lvl);
      // two cycles of slack for load and tick phase
      if (e.len > 0) chk(len + 2 >= e.len && len <= e.len + 2, 1);
    end
  end

  // hang guard
  always @(posedge clk_i) begin
    cyc_n <= cyc_n + 1;
    if (cyc_n == 20000) begin
      fail_count++;
      conclude();
    end
  end

  initial begin
    void'($urandom(24));
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    foreach (ra[k]) begin
      wb(1'b0, ra[k], 32'h0, 4'hF);
      chk(rd, 32'h0);
    end
    // a write with no byte lanes must not start a run
    wb(1'b1, 9'h000, 32'h1, 4'h0);
    wb(1'b0, 9'h000, 32'h0, 4'hF);
    chk(rd, 32'h0);
    chk(dout, 1'b0);
    $display("reset values done");
    for (int k = 0; k < 64; k++) begin
      dur[k] = 23'($urandom % 4);
      if (k == 0) dur[k] = 23'h3;
      if (k == 1) dur[k] = 23'h2;
      if (k == 16) dur[k] = 23'h0;
      if (k == 32) dur[k] = 23'h000010;
      wb(1'b1, 9'h100 + 9'(k * 4), {9'h0, dur[k]}, 4'hF);
    end
    $display("patterns loaded");
    for (int p = 0; p < 4; p++) begin
      predict(p);
      wb(1'b1, 9'h000, 32'(p << 4) | 32'h1, 4'hF);
      for (int w = 0; q.size() > 0 && w < 3000; w++) @(posedge clk_i);
      chk(q.size(), 0);
      wb(1'b1, 9'h000, 32'h0, 4'hF);
      // let the stop event pass before the next notes are queued
      repeat (6) @(posedge clk_i);
      chk(dout, 1'b0);
      $display("pattern %0d done", p);
    end
    // start gated by segment and external hold, then frozen mid-step
    hold <= 1'b1;
    wb(1'b1, 9'h000, 32'h7, 4'hF);
    repeat (20) @(posedge clk_i);
    chk(dout, 1'b0);
    wb(1'b0, 9'h004, 32'h0, 4'hF);
    chk(rd[dts_pkg::STAT_HOLD], 1'b1);
    chk(rd[dts_pkg::STAT_RUN], 1'b1);
    chk(rd[7:4], 4'h0);
    seg <= 1'b1;
    hold <= 1'b0;
    for (int w = 0; dout !== 1'b1 && w < 10; w++) @(posedge clk_i);
    chk(dout, 1'b1);
    hold <= 1'b1;
    repeat (2) @(posedge clk_i);
    wb(1'b0, dts_pkg::ADDR_REM, 32'h0, 4'hF);
    r1 = rd;
    chk(r1, 32'(tenths(dur[0])));
    repeat (20) @(posedge clk_i);
    wb(1'b0, dts_pkg::ADDR_REM, 32'h0, 4'hF);
    chk(rd, r1);
    chk(dout, 1'b1);
    hold <= 1'b0;
    for (int w = 0; dout !== 1'b0 && w < 40; w++) @(posedge clk_i);
    chk(dout, 1'b0);
    $display("hold test done");
    conclude();
  end
endmodule
